// [epcd_pkg.sv]
package epcd_pkg;

    // Command bytes decoded by the interpreter.
    localparam logic [7:0] CMD_POS_READ = 8'h42;
    localparam logic [7:0] CMD_POS_SET = 8'h43;
    localparam logic [7:0] CMD_ANALOG_READ = 8'h44;
    localparam logic [7:0] CMD_CNT_READ = 8'h46;
    localparam logic [7:0] CMD_CNT_INC = 8'h47;
    localparam logic [7:0] CMD_CNT_CLR = 8'h49;
    localparam logic [7:0] CMD_DATA_READ = 8'h4a;
    localparam logic [7:0] CMD_DATA_STORE = 8'h4b;
    localparam logic [7:0] CMD_FIELD_STAT = 8'h4c;
    localparam logic [7:0] CMD_FIELD_MAKE = 8'h4d;
    localparam logic [7:0] CMD_FREE_MEM = 8'h4e;
    localparam logic [7:0] CMD_CODE_CHG = 8'h4f;
    localparam logic [7:0] CMD_STAT_READ = 8'h50;
    localparam logic [7:0] CMD_TYPE_READ = 8'h52;
    localparam logic [7:0] CMD_RESET = 8'h53;
    localparam logic [7:0] CMD_ADDR_SET = 8'h55;
    localparam logic [7:0] CMD_SERIAL_READ = 8'h56;
    localparam logic [7:0] CMD_IFACE_CFG = 8'h57;

    // Access code held at delivery.
    localparam logic [7:0] ACCESS_CODE_RST = 8'h55;

    // Only analog channel that the analog read accepts.
    localparam logic [7:0] ANALOG_TEMP_CH = 8'h48;

    // Status codes.
    localparam logic [7:0] ST_OK = 8'h00;
    localparam logic [7:0] ST_I2C_DEAD = 8'h05;
    localparam logic [7:0] ST_INT_CSUM = 8'h06;
    localparam logic [7:0] ST_WATCHDOG = 8'h07;
    localparam logic [7:0] ST_PARITY = 8'h09;
    localparam logic [7:0] ST_FRAME_CSUM = 8'h0a;
    localparam logic [7:0] ST_UNKNOWN_CMD = 8'h0b;
    localparam logic [7:0] ST_BAD_LEN = 8'h0c;
    localparam logic [7:0] ST_BAD_ARG = 8'h0d;
    localparam logic [7:0] ST_READ_ONLY = 8'h0e;
    localparam logic [7:0] ST_BAD_CODE = 8'h0f;
    localparam logic [7:0] ST_FIXED_SIZE = 8'h10;
    localparam logic [7:0] ST_ADDR_RANGE = 8'h11;
    localparam logic [7:0] ST_NO_FIELD = 8'h12;
    localparam logic [7:0] ST_XMIT_CURR = 8'h1d;
    localparam logic [7:0] ST_TEMP_CRIT = 8'h1e;
    localparam logic [7:0] ST_OVERSPEED = 8'h1f;
    localparam logic [7:0] ST_ST_UNRELIABLE = 8'h20;
    localparam logic [7:0] ST_MT_ERR_BASE = 8'h21;

    // Number of multiturn error causes, coded from the base upward.
    localparam int MT_ERR_NUM = 3;

    // Expected data byte count per command, access code included.
    localparam logic [3:0] LEN_ZERO = 4'h0;
    localparam logic [3:0] LEN_ONE = 4'h1;
    localparam logic [3:0] LEN_TWO = 4'h2;
    localparam logic [3:0] LEN_FOUR = 4'h4;
    localparam logic [3:0] LEN_FIVE = 4'h5;
    localparam logic [3:0] LEN_ANY = 4'hf;

    // One decoded command frame as it leaves the byte framer.
    typedef struct packed {
        logic [7:0] cmd;
        logic [3:0] len;
        logic [7:0] arg0;
        logic [7:0] arg1;
        logic csum_err;
        logic parity_err;
    } epcd_frame_t;

    // Outcome of a frame handed to the function units.
    typedef struct packed {
        logic [4:0] func;
        logic [7:0] arg0;
        logic [7:0] arg1;
    } epcd_exec_t;

    // Sensed fault conditions from the rest of the encoder.
    typedef struct packed {
        logic overspeed;
        logic st_unreliable;
        logic [MT_ERR_NUM-1:0] mt_err;
        logic temp_crit;
        logic xmit_crit;
        logic int_csum;
        logic i2c_dead;
        logic watchdog_rst;
    } epcd_faults_t;

endpackage : epcd_pkg

// [epcd_fault_prio.sv]
`timescale 1ns/1ps
`default_nettype none

// Picks the most urgent sensed fault and gives its status code.
module epcd_fault_prio
    import epcd_pkg::*;
(
    input wire epcd_faults_t faults,
    output logic active,
    output logic [7:0] code
);

    // Multiturn errors map to consecutive codes; lowest index wins.
    logic [MT_ERR_NUM-1:0] mt_hit;
    logic [7:0] mt_code [MT_ERR_NUM+1];

    // Each multiturn cause offers its code in a priority chain.
    assign mt_code[MT_ERR_NUM] = ST_OK;
    genvar gi;
    generate
        for (gi = 0; gi < MT_ERR_NUM; gi++) begin : g_mt
            assign mt_hit[gi] = faults.mt_err[gi];
            assign mt_code[gi] = mt_hit[gi] ? 8'(ST_MT_ERR_BASE + gi) : mt_code[gi+1];
        end
    endgenerate

    // Priority: initialization faults, then position, then environment.
    always_comb begin
        active = 1'b1;
        if (faults.watchdog_rst) begin
            code = ST_WATCHDOG; // [RULE_16]
        end else if (faults.int_csum) begin
            code = ST_INT_CSUM; // [RULE_15]
        end else if (faults.i2c_dead) begin
            code = ST_I2C_DEAD; // [RULE_15]
        end else if (faults.overspeed) begin
            code = ST_OVERSPEED; // [RULE_12]
        end else if (faults.st_unreliable) begin
            code = ST_ST_UNRELIABLE; // [RULE_13]
        end else if (|mt_hit) begin
            code = mt_code[0]; // [RULE_13]
        end else if (faults.temp_crit) begin
            code = ST_TEMP_CRIT; // [RULE_14]
        end else if (faults.xmit_crit) begin
            code = ST_XMIT_CURR; // [RULE_14]
        end else begin
            active = 1'b0;
            code = ST_OK;
        end
    end

endmodule : epcd_fault_prio

`default_nettype wire

// [epcd_decoder.sv]
// Notes on behaviour
// (RULE_01) Status read answers 00h when fault free.
// (RULE_02) Protected commands carry an access code byte.
// (RULE_03) Access code resets to 55h.
// (RULE_04) Interface configuration 57h is protected.
// (RULE_05) Unknown command byte reports 0Bh.
// (RULE_06) Frame checksum 0Ah, parity 09h.
// (RULE_07) Wrong data byte count reports 0Ch.
// (RULE_08) Disallowed argument reports 0Dh.
// (RULE_09) Write to read-only field reports 0Eh.
// (RULE_10) Wrong access code rejects, reports 0Fh.
// (RULE_11) Field errors 10h, 11h, 12h.
// (RULE_12) Overspeed reports 1Fh, no position.
// (RULE_13) Singleturn 20h, multiturn 21h to 23h.
// (RULE_14) Temperature 1Eh, transmitter current 1Dh.
// (RULE_15) Internal checksum 06h, I2C dead 05h.
// (RULE_16) Watchdog restart reports 07h.
// (RULE_17) Decode 42h, 43h, 56h.
// (RULE_18) Decode data memory commands 4Ah to 4Fh.
// (RULE_19) Decode 53h reset, 55h address.
// (RULE_20) Latest fault held until status read.
`timescale 1ns/1ps
`default_nettype none

// Decodes parameter channel command frames and keeps the status byte.
module epcd_decoder
    import epcd_pkg::*;
#(
    parameter int FIELD_NUM = 16,
    parameter int FIELD_WORDS = 64
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic frame_valid,
    input wire epcd_frame_t frame,
    input wire epcd_faults_t faults,
    input wire logic [FIELD_NUM-1:0] field_exists,
    input wire logic [FIELD_NUM-1:0] field_writable,
    input wire logic [FIELD_NUM-1:0] field_sized,
    output logic exec_valid_ff,
    output epcd_exec_t exec_ff,
    output logic resp_valid_ff,
    output logic [7:0] resp_status_ff,
    output logic resp_ok_ff,
    output logic pos_blocked_ff,
    output logic [7:0] access_code_ff
);

    // Function numbers handed to the executing units.
    localparam logic [4:0] FN_POS_READ = 5'h01;
    localparam logic [4:0] FN_POS_SET = 5'h02;
    localparam logic [4:0] FN_ANALOG = 5'h03;
    localparam logic [4:0] FN_CNT_READ = 5'h04;
    localparam logic [4:0] FN_CNT_INC = 5'h05;
    localparam logic [4:0] FN_CNT_CLR = 5'h06;
    localparam logic [4:0] FN_DATA_READ = 5'h07;
    localparam logic [4:0] FN_DATA_STORE = 5'h08;
    localparam logic [4:0] FN_FIELD_STAT = 5'h09;
    localparam logic [4:0] FN_FIELD_MAKE = 5'h0a;
    localparam logic [4:0] FN_FREE_MEM = 5'h0b;
    localparam logic [4:0] FN_CODE_CHG = 5'h0c;
    localparam logic [4:0] FN_STAT_READ = 5'h0d;
    localparam logic [4:0] FN_TYPE_READ = 5'h0e;
    localparam logic [4:0] FN_RESET = 5'h0f;
    localparam logic [4:0] FN_ADDR_SET = 5'h10;
    localparam logic [4:0] FN_SERIAL = 5'h11;
    localparam logic [4:0] FN_IFACE = 5'h12;
    localparam logic [4:0] FN_NONE = 5'h00;
    localparam int FIDX_W = $clog2(FIELD_NUM);

    // Decoder sequencing states.
    typedef enum logic [1:0] {
        EPCD_IDLE,
        EPCD_CHECK,
        EPCD_ANSWER
    } epcd_state_t;

    epcd_state_t state_ff; // Current decoder state.
    epcd_frame_t frm_ff; // Frame under decode.
    logic [7:0] held_fault_ff; // Latest sensed or protocol fault.
    logic fault_active; // A sensed fault is present now.
    logic [7:0] fault_code; // Code of the sensed fault.
    logic [4:0] fn; // Decoded function number.
    logic [3:0] need_len; // Expected data byte count.
    logic protected_cmd; // Command carries an access code.
    logic field_write; // Command writes a data field.
    logic [7:0] err_code; // Protocol error of this frame.
    logic [FIDX_W-1:0] fidx; // Field index from the first argument.
    logic [7:0] nxt_code; // Access code after this frame.

    // Priority encoder for sensed fault inputs.
    epcd_fault_prio epcd_fault_prio_inst (
        .faults(faults),
        .active(fault_active),
        .code(fault_code)
    );

    // Field index is the low bits of the first argument.
    assign fidx = frm_ff.arg0[FIDX_W-1:0];

    // Command byte to function number and required length.
    always_comb begin
        fn = FN_NONE;
        need_len = LEN_ZERO;
        protected_cmd = 1'b0;
        field_write = 1'b0;
        case (frm_ff.cmd)
            // Position read has no arguments.
            CMD_POS_READ: begin
                fn = FN_POS_READ; // [RULE_17]
            end
            // Position set carries a four byte value.
            CMD_POS_SET: begin
                fn = FN_POS_SET; // [RULE_17]
                need_len = LEN_FOUR;
            end
            // Analog read names one channel.
            CMD_ANALOG_READ: begin
                fn = FN_ANALOG;
                need_len = LEN_ONE;
            end
            // Counter read carries no data.
            CMD_CNT_READ: begin
                fn = FN_CNT_READ;
            end
            // Counter increment carries no data.
            CMD_CNT_INC: begin
                fn = FN_CNT_INC;
            end
            // Counter clear carries no data.
            CMD_CNT_CLR: begin
                fn = FN_CNT_CLR;
            end
            // Data read names a field and a word.
            CMD_DATA_READ: begin
                fn = FN_DATA_READ; // [RULE_18]
                need_len = LEN_TWO;
            end
            // Data store length varies with the payload.
            CMD_DATA_STORE: begin
                fn = FN_DATA_STORE; // [RULE_18]
                need_len = LEN_ANY;
                field_write = 1'b1;
            end
            // Field status names a field.
            CMD_FIELD_STAT: begin
                fn = FN_FIELD_STAT; // [RULE_18]
                need_len = LEN_ONE;
            end
            // Field creation names a field and a size.
            CMD_FIELD_MAKE: begin
                fn = FN_FIELD_MAKE; // [RULE_18]
                need_len = LEN_TWO;
            end
            // Free memory query carries no data.
            CMD_FREE_MEM: begin
                fn = FN_FREE_MEM; // [RULE_18]
            end
            // Code change carries the old and the new code.
            CMD_CODE_CHG: begin
                fn = FN_CODE_CHG; // [RULE_18]
                need_len = LEN_TWO;
            end
            // Status read carries no data.
            CMD_STAT_READ: begin
                fn = FN_STAT_READ;
            end
            // Type label read carries no data.
            CMD_TYPE_READ: begin
                fn = FN_TYPE_READ;
            end
            // Reset request carries no data.
            CMD_RESET: begin
                fn = FN_RESET; // [RULE_19]
            end
            // Address assignment carries the new address.
            CMD_ADDR_SET: begin
                fn = FN_ADDR_SET; // [RULE_19]
                need_len = LEN_ONE;
            end
            // Serial number read carries no data.
            CMD_SERIAL_READ: begin
                fn = FN_SERIAL; // [RULE_17]
            end
            // Interface setup is guarded by the access code.
            CMD_IFACE_CFG: begin
                fn = FN_IFACE;
                need_len = LEN_TWO;
                protected_cmd = 1'b1; // [RULE_04]
            end
            // Anything else is reported as unknown.
            default: begin
                fn = FN_NONE;
            end
        endcase
    end

    // Protocol checks in the order the host would see them.
    always_comb begin
        err_code = ST_OK;
        if (frm_ff.parity_err) begin
            // A damaged character makes every other byte suspect.
            err_code = ST_PARITY; // [RULE_06]
        end else if (frm_ff.csum_err) begin
            // The frame arrived whole but its sum disagrees.
            err_code = ST_FRAME_CSUM; // [RULE_06]
        end else if (fn == FN_NONE) begin
            // Nothing further can be judged for a foreign byte.
            err_code = ST_UNKNOWN_CMD; // [RULE_05]
        end else if (need_len != LEN_ANY && frm_ff.len != need_len) begin
            // Arguments cannot be trusted when the count is off.
            err_code = ST_BAD_LEN; // [RULE_07]
        end else if (protected_cmd && frm_ff.arg0 != access_code_ff) begin
            // Guarded settings stay untouched without the code.
            err_code = ST_BAD_CODE; // [RULE_02] [RULE_10]
        end else if (fn == FN_CODE_CHG && frm_ff.arg0 != access_code_ff) begin
            // A new code is only taken against the old one.
            err_code = ST_BAD_CODE; // [RULE_10]
        end else if (fn == FN_ANALOG && frm_ff.arg0 != ANALOG_TEMP_CH) begin
            // Only the temperature channel may be read.
            err_code = ST_BAD_ARG; // [RULE_08]
        end else if (fn == FN_FIELD_MAKE && field_sized[fidx]) begin
            // Fixed fields keep the size they were built with.
            err_code = ST_FIXED_SIZE; // [RULE_11]
        end else if ((fn == FN_DATA_READ || field_write || fn == FN_FIELD_STAT)
                     && (32'(frm_ff.arg0) >= FIELD_NUM || !field_exists[fidx])) begin
            // The index must name a field that is present.
            err_code = ST_NO_FIELD; // [RULE_11]
        end else if ((fn == FN_DATA_READ || field_write)
                     && 32'(frm_ff.arg1) >= FIELD_WORDS) begin
            // The word address must lie inside the field.
            err_code = ST_ADDR_RANGE; // [RULE_11]
        end else if (field_write && !field_writable[fidx]) begin
            // Read-only fields refuse every store.
            err_code = ST_READ_ONLY; // [RULE_09]
        end else if (fn == FN_POS_READ && faults.overspeed) begin
            // No position is formed above the speed limit, whatever else is sensed.
            err_code = ST_OVERSPEED; // [RULE_12]
        end
    end

    // A changed code takes effect only from an accepted change command.
    always_comb begin
        nxt_code = access_code_ff;
        if (state_ff == EPCD_CHECK && err_code == ST_OK && fn == FN_CODE_CHG) begin
            nxt_code = frm_ff.arg1;
        end
    end

    // Sequencer: capture, check, answer.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            state_ff <= EPCD_IDLE;
            frm_ff <= '0;
        end else if (clk_en) begin
            case (state_ff)
                EPCD_IDLE: begin
                    if (frame_valid) begin
                        frm_ff <= frame;
                        state_ff <= EPCD_CHECK;
                    end
                end
                // The checks settle during this cycle.
                EPCD_CHECK: begin
                    state_ff <= EPCD_ANSWER;
                end
                // The answer is out; new frames wait until idle.
                EPCD_ANSWER: begin
                    state_ff <= EPCD_IDLE;
                end
                default: state_ff <= EPCD_IDLE;
            endcase
        end
    end

    // Stored access code.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            access_code_ff <= ACCESS_CODE_RST; // [RULE_03]
        end else if (clk_en) begin
            access_code_ff <= nxt_code;
        end
    end

    // Held fault: new faults set it, a status read clears it; set wins.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            held_fault_ff <= ST_OK;
        end else if (clk_en) begin
            if (state_ff == EPCD_CHECK && err_code != ST_OK) begin
                held_fault_ff <= err_code; // [RULE_20]
            end else if (fault_active) begin
                held_fault_ff <= fault_code; // [RULE_20]
            end else if (state_ff == EPCD_CHECK && fn == FN_STAT_READ) begin
                held_fault_ff <= ST_OK; // [RULE_20]
            end
        end
    end

    // Response and execution strobes.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            resp_valid_ff <= 1'b0;
            resp_status_ff <= ST_OK;
            resp_ok_ff <= 1'b0;
            exec_valid_ff <= 1'b0;
            exec_ff <= '0;
        end else if (clk_en) begin
            resp_valid_ff <= 1'b0;
            exec_valid_ff <= 1'b0;
            if (state_ff == EPCD_CHECK) begin
                resp_valid_ff <= 1'b1;
                resp_ok_ff <= (err_code == ST_OK);
                if (err_code != ST_OK) begin
                    resp_status_ff <= err_code; // [RULE_10]
                end else if (fn == FN_STAT_READ) begin
                    resp_status_ff <= held_fault_ff; // [RULE_01] [RULE_20]
                end else begin
                    resp_status_ff <= ST_OK;
                end
                if (err_code == ST_OK) begin
                    exec_valid_ff <= 1'b1;
                    exec_ff.func <= fn;
                    exec_ff.arg0 <= frm_ff.arg0;
                    exec_ff.arg1 <= frm_ff.arg1;
                end
            end
        end
    end

    // Position output is blocked while overspeed is sensed.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            pos_blocked_ff <= 1'b0;
        end else if (clk_en) begin
            pos_blocked_ff <= faults.overspeed; // [RULE_12]
        end
    end

endmodule : epcd_decoder

`default_nettype wire

// [epcd_decoder_assertions.sv]
`timescale 1ns/1ps
`default_nettype none

// Watches the decoder ports for answer timing and status code relations.
module epcd_checker
    import epcd_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic frame_valid,
    input wire epcd_frame_t frame,
    input wire epcd_faults_t faults,
    input wire logic exec_valid_ff,
    input wire logic resp_valid_ff,
    input wire logic [7:0] resp_status_ff,
    input wire logic resp_ok_ff,
    input wire logic [7:0] access_code_ff
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn || !clk_en);

    // A frame taken by the decoder.
    sequence take_s;
        frame_valid && clk_en;
    endsequence

    // A taken frame with clean framing.
    sequence clean_s;
        frame_valid && clk_en && !frame.csum_err && !frame.parity_err;
    endsequence

    // A clean position read while overspeed stands for two cycles.
    sequence os_req_s;
        clean_s ##0 (frame.cmd == CMD_POS_READ && frame.len == LEN_ZERO && faults.overspeed)
            ##1 faults.overspeed;
    endsequence

    resp_lat_a: assert property (take_s |-> ##2 resp_valid_ff)
        else $error("answer not two cycles after frame");
    resp_pulse_a: assert property (resp_valid_ff |=> !resp_valid_ff)
        else $error("answer pulse too long");
    exec_pair_a: assert property (exec_valid_ff == (resp_valid_ff && resp_ok_ff))
        else $error("execute without good answer");
    parity_code_a: assert property (take_s ##0 frame.parity_err |->
        ##2 resp_status_ff == ST_PARITY && !resp_ok_ff) else $error("parity code wrong");
    csum_code_a: assert property (take_s ##0 (frame.csum_err && !frame.parity_err) |->
        ##2 resp_status_ff == ST_FRAME_CSUM) else $error("checksum code wrong");
    unknown_cmd_a: assert property (clean_s ##0 (frame.cmd inside {[8'h00:8'h41], 8'h45,
        8'h48, 8'h51, 8'h54, [8'h58:8'hff]}) |-> ##2 resp_status_ff == ST_UNKNOWN_CMD)
        else $error("unknown command code wrong");
    code_bad_a: assert property (clean_s ##0 (frame.cmd == CMD_IFACE_CFG &&
        frame.len == LEN_TWO && frame.arg0 != access_code_ff) |->
        ##2 resp_status_ff == ST_BAD_CODE && !exec_valid_ff) else $error("bad code accepted");
    overspeed_a: assert property (os_req_s |=> resp_status_ff == ST_OVERSPEED &&
        !exec_valid_ff) else $error("position given at overspeed");
    status_hold_a: assert property (!resp_valid_ff |-> $stable(resp_status_ff))
        else $error("status changed without answer");
    code_rst_a: assert property ($rose(rstn) |-> access_code_ff == ACCESS_CODE_RST)
        else $error("access code not at delivery value");
endmodule : epcd_checker

`default_nettype wire

// [epcd_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

// Drive controller side: hands whole frames to the decoder, one at a time.
module epcd_host_model
    import epcd_pkg::*;
(
    input wire logic clock,
    output logic frame_valid,
    output epcd_frame_t frame
);
    initial frame_valid = 1'b0;
    initial frame = '0;

    // Sends one frame; the access code travels in arg0.
    task send(input logic [7:0] c, input logic [3:0] l, input logic [7:0] a0,
        input logic [7:0] a1, input logic [1:0] fl);
        epcd_frame_t f;
        f = '{cmd: c, len: l, arg0: a0, arg1: a1, csum_err: fl[1], parity_err: fl[0]};
        @(posedge clock);
        frame_valid <= 1'b1;
        frame <= f;
        @(posedge clock);
        frame_valid <= 1'b0;
        // A released frame shows the inverse so stale data never looks valid.
        frame <= ~f;
        #1;
    endtask : send
endmodule : epcd_host_model

`default_nettype wire

// [encoder_param_command_decoder_bench.sv]
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the parameter channel command decoder.
module encoder_param_command_decoder_bench
    import epcd_pkg::*;
();
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic frame_valid;
    epcd_frame_t frame;
    epcd_faults_t faults = '0;
    epcd_exec_t exec_ff;
    logic exec_valid_ff, resp_valid_ff, resp_ok_ff, pos_blocked_ff;
    logic [7:0] resp_status_ff, access_code_ff;
    logic [7:0] st;
    logic ok, ex;
    int miscompares = 0;
    int checks = 0;
    // Legal commands: cmd, len, arg0, arg1.
    localparam logic [31:0] OK_T [18] = '{32'h42000000, 32'h43040000, 32'h44014800,
        32'h46000000, 32'h47000000, 32'h49000000, 32'h4a020000, 32'h4b020000, 32'h4c010000,
        32'h4d020010, 32'h4e000000, 32'h4f025555, 32'h50000000, 32'h52000000, 32'h53000000,
        32'h55014000, 32'h56000000, 32'h570255e4};
    // Faulty frames: expected code, flags, cmd, len, arg0, arg1.
    localparam logic [47:0] ERR_T [10] = '{48'h090142000000, 48'h0a0242000000,
        48'h0b0041000000, 48'h0c0042010000, 48'h0f005702aae4, 48'h0d0044014700,
        48'h10004d020110, 48'h12004a020200, 48'h11004a020040, 48'h0e004b020300};
    // Status code for each fault bit, lowest bit first.
    localparam logic [7:0] FLT_T [10] = '{8'h07, 8'h05, 8'h06, 8'h1d, 8'h1e, 8'h21, 8'h22,
        8'h23, 8'h20, 8'h1f};

    always #4 clock = ~clock;

    epcd_host_model epcd_host_model_inst (.clock(clock), .frame_valid(frame_valid),
        .frame(frame));
    // Field 1 has a fixed size, field 2 is missing, field 3 is read-only.
    epcd_decoder epcd_decoder_inst (.clock(clock), .rstn(rstn), .clk_en(1'b1),
        .frame_valid(frame_valid), .frame(frame), .faults(faults),
        .field_exists(16'hfffb), .field_writable(16'hfff7), .field_sized(16'h0002),
        .exec_valid_ff(exec_valid_ff), .exec_ff(exec_ff), .resp_valid_ff(resp_valid_ff),
        .resp_status_ff(resp_status_ff), .resp_ok_ff(resp_ok_ff),
        .pos_blocked_ff(pos_blocked_ff), .access_code_ff(access_code_ff));

    // Compares one value and counts it.
    task chk(input logic [7:0] s, input logic [7:0] e);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    endtask : chk

    // Sends a frame and captures the answer under a bounded wait.
    task run(input logic [31:0] w, input logic [1:0] fl);
        int k;
        epcd_host_model_inst.send(w[31:24], w[19:16], w[15:8], w[7:0], fl);
        for (k = 0; k < 6 && resp_valid_ff !== 1'b1; k++) begin
            @(posedge clock);
            #1;
        end
        if (k == 6) begin
            miscompares++;
            $display("wrong value at %0t: no answer", $time);
        end
        st = resp_status_ff;
        ok = resp_ok_ff;
        ex = exec_valid_ff;
    endtask : run

    task t_reset();
        chk(access_code_ff, 8'h55);
        chk({7'h0, pos_blocked_ff}, 8'h00);
        run(32'h50000000, 2'b00);
        chk(st, 8'h00);
    endtask : t_reset

    task t_decode();
        for (int i = 0; i < 18; i++) begin
            run(OK_T[i], 2'b00);
            chk({6'h0, ok, ex}, 8'h03);
            chk(exec_ff.arg0, OK_T[i][15:8]);
            chk(exec_ff.arg1, OK_T[i][7:0]);
        end
    endtask : t_decode

    // Each fault is read back by the next status read, then gone.
    task t_errors();
        for (int i = 0; i < 10; i++) begin
            run(ERR_T[i][31:0], ERR_T[i][33:32]);
            chk({ok, ex, 6'h0}, 8'h00);
            run(32'h50000000, 2'b00);
            chk(st, ERR_T[i][47:40]);
        end
        run(32'h50000000, 2'b00);
        chk(st, 8'h00);
    endtask : t_errors

    task t_faults();
        for (int i = 0; i < 10; i++) begin
            @(posedge clock);
            faults <= epcd_faults_t'(10'h001 << i);
            run(32'h50000000, 2'b00);
            chk(st, FLT_T[i]);
            if (i == 9) begin
                run(32'h42000000, 2'b00);
                chk({st[6:0], ex}, {7'h1f, 1'b0});
                chk({7'h0, pos_blocked_ff}, 8'h01);
            end
            @(posedge clock);
            faults <= '0;
            run(32'h50000000, 2'b00);
            chk(st, FLT_T[i]);
        end
    endtask : t_faults

    task t_code();
        run(32'h4f0255a7, 2'b00);
        chk(access_code_ff, 8'ha7);
        run(32'h570255e4, 2'b00);
        chk({st, ex}, {8'h0f, 1'b0});
        run(32'h5702a7e4, 2'b00);
        chk({7'h0, ex}, 8'h01);
        @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        #1;
        chk(access_code_ff, 8'h55);
    endtask : t_code

    // Prints the verdict and ends the run.
    task print_verdict();
        if (miscompares == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    // Main sequence after a two cycle reset.
    initial begin
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        #1;
        t_reset();
        t_decode();
        t_errors();
        t_faults();
        t_code();
        print_verdict();
    end

    // Cuts a hang short well beyond the expected run length.
    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end
endmodule : encoder_param_command_decoder_bench

bind epcd_decoder epcd_checker checker_inst (.clock(clock), .rstn(rstn), .clk_en(clk_en),
    .frame_valid(frame_valid), .frame(frame), .faults(faults),
    .exec_valid_ff(exec_valid_ff), .resp_valid_ff(resp_valid_ff),
    .resp_status_ff(resp_status_ff), .resp_ok_ff(resp_ok_ff),
    .access_code_ff(access_code_ff));

`default_nettype wire
